/* rtl/spc_pkg.sv */
/*
  Constants for the serial interface pin-control and bit-rate block:
  register offsets, field positions, reset values and enumerations.
  Assumes a 32-bit AXI4-Lite register port, one aligned word per register.
*/
package spc_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PIN_MODE = 8'h00;
  localparam logic [7:0] OFS_BIT_RATE = 8'h04;
  localparam logic [7:0] OFS_MODE_CTRL = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int POS_MODE_FAULT_EN = 4;
  localparam int POS_BIDIR_OE = 3;
  localparam int POS_STOP_IN_WAIT = 1;
  localparam int POS_SINGLE_WIRE = 0;
  localparam int POS_MASTER = 0;
  localparam int POS_SS_OE = 1;
  localparam int POS_WAIT_MODE = 2;
  localparam int POS_IRQ_FAULT = 0;
  localparam logic [7:0] PIN_MODE_IMPL = 8'h1B;
  localparam logic [7:0] BIT_RATE_IMPL = 8'h77;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PIN_MODE = 8'h00;
  localparam logic [7:0] RST_BIT_RATE = 8'h00;
  localparam logic [2:0] RST_MODE_CTRL = 3'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // Select pin function
  typedef enum logic [1:0] {
    SS_SLAVE_IN = 2'b00,
    SS_PORT_IO = 2'b01,
    SS_FAULT_IN = 2'b10,
    SS_AUTO_OUT = 2'b11
  } spc_ss_fn_e;

endpackage

/* rtl/spc_pin_rate.sv */
/*
  Serial interface pin control and master bit-rate generator with an
  AXI4-Lite register slave and a mode fault interrupt.
  Assumes the shifter outside consumes bit_rate_tick, drives serial data
  and select levels, and that pin inputs are synchronous to aclk.
*/
`timescale 1ns/1ns
module spc_pin_rate
  import spc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_in_wait,
  input wire logic shifter_out,
  input wire logic shifter_ss_level,
  output logic shifter_in,
  output logic bit_rate_tick,
  output logic if_clk_run,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_i,
  output logic ss_o,
  output logic ss_oe,
  output logic ss_port_io,
  output logic mode_fault_flag,
  output logic irq
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0] pin_mode;
  logic [7:0] bit_rate;
  logic [2:0] mode_ctrl;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic do_read;
  logic [31:0] next_rdata;
  logic rd_status;
  logic master;
  logic single_wire;
  logic fault_event;
  spc_ss_fn_e ss_fn;

  assign master = mode_ctrl[POS_MASTER];
  assign single_wire = pin_mode[POS_SINGLE_WIRE];

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  // Address and data may arrive in either order; both are latched
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Ready is registered so it comes straight from a flip-flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == OFS_PIN_MODE || aw_addr == OFS_BIT_RATE ||
          aw_addr == OFS_MODE_CTRL || aw_addr == OFS_IRQ_STATUS ||
          aw_addr == OFS_IRQ_MASK) begin
        s_axi_bresp <= AXI_OKAY;
      end else begin
        s_axi_bresp <= AXI_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Only the low byte lane carries these registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_mode <= RST_PIN_MODE;
    end else if (do_write && w_strb[0] && aw_addr == OFS_PIN_MODE) begin
      pin_mode <= w_data[7:0] & PIN_MODE_IMPL;
    end
  end

  // Never blocked by transfer state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_rate <= RST_BIT_RATE;
    end else if (do_write && w_strb[0] && aw_addr == OFS_BIT_RATE) begin
      bit_rate <= w_data[7:0] & BIT_RATE_IMPL;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ctrl <= RST_MODE_CTRL;
    end else if (do_write && w_strb[0] && aw_addr == OFS_MODE_CTRL) begin
      mode_ctrl <= w_data[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= 8'h00;
    end else if (do_write && w_strb[0] && aw_addr == OFS_IRQ_MASK) begin
      irq_mask <= w_data[7:0];
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign rd_status = do_read && s_axi_araddr == OFS_IRQ_STATUS;

  // Read mux; reserved bits return zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (s_axi_araddr == OFS_PIN_MODE) begin
      next_rdata = {24'h00_0000, pin_mode & PIN_MODE_IMPL};
    end else if (s_axi_araddr == OFS_BIT_RATE) begin
      next_rdata = {24'h00_0000, bit_rate};
    end else if (s_axi_araddr == OFS_MODE_CTRL) begin
      next_rdata = {29'h0000_0000, mode_ctrl};
    end else if (s_axi_araddr == OFS_IRQ_STATUS) begin
      next_rdata = {24'h00_0000, irq_status};
    end else if (s_axi_araddr == OFS_IRQ_MASK) begin
      next_rdata = {24'h00_0000, irq_mask};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else if (do_read) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      if (s_axi_araddr == OFS_PIN_MODE || s_axi_araddr == OFS_BIT_RATE ||
          s_axi_araddr == OFS_MODE_CTRL ||
          s_axi_araddr == OFS_IRQ_STATUS ||
          s_axi_araddr == OFS_IRQ_MASK) begin
        s_axi_rresp <= AXI_OKAY;
      end else begin
        s_axi_rresp <= AXI_SLVERR;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Select pin function and mode fault
  // ---------------------------------------------------------------
  // Pin role from master, fault enable and select output enable
  always_comb begin
    if (!master) begin
      ss_fn = SS_SLAVE_IN;
    end else if (!pin_mode[POS_MODE_FAULT_EN]) begin
      ss_fn = SS_PORT_IO;
    end else if (mode_ctrl[POS_SS_OE]) begin
      ss_fn = SS_AUTO_OUT;
    end else begin
      ss_fn = SS_FAULT_IN;
    end
  end

  // Another master pulling select low is a fault
  assign fault_event = (ss_fn == SS_FAULT_IN) && !ss_i;

  // Sticky status; a new event wins over the clear-on-read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 8'h00;
    end else begin
      irq_status <= (rd_status ? 8'h00 : irq_status) |
                    {7'h00, fault_event};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_fault_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      mode_fault_flag <= irq_status[POS_IRQ_FAULT] || fault_event;
      irq <= |(irq_status & irq_mask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ss_o <= 1'b1;
      ss_oe <= 1'b0;
      ss_port_io <= 1'b0;
    end else begin
      ss_o <= shifter_ss_level;
      ss_oe <= (ss_fn == SS_AUTO_OUT);
      ss_port_io <= (ss_fn == SS_PORT_IO);
    end
  end

  // ---------------------------------------------------------------
  // Data pin steering
  // ---------------------------------------------------------------
  // Master drives the out/in pin, slave the in/out pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mosi_o <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
      shifter_in <= 1'b0;
    end else begin
      mosi_o <= shifter_out;
      miso_o <= shifter_out;
      if (single_wire) begin
        // Output enable bit gates the single data pin
        mosi_oe <= master && pin_mode[POS_BIDIR_OE];
        miso_oe <= !master && pin_mode[POS_BIDIR_OE];
        shifter_in <= master ? mosi_i : miso_i;
      end else begin
        // Output enable bit ignored; separate pins
        mosi_oe <= master;
        miso_oe <= !master;
        shifter_in <= master ? miso_i : mosi_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Bit-rate generator
  // ---------------------------------------------------------------
  logic [2:0] pre_cnt;
  logic pre_tick;
  logic [7:0] rate_cnt;
  logic [7:0] rate_last;
  logic clk_run;

  // Stop in wait freezes both counters
  assign clk_run = !(pin_mode[POS_STOP_IN_WAIT] &&
                     mode_ctrl[POS_WAIT_MODE] && cpu_in_wait);
  assign pre_tick = clk_run && (pre_cnt >= bit_rate[6:4]);
  assign rate_last = 8'((9'h002 << bit_rate[2:0]) - 9'h001);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt <= 3'h0;
    end else if (pre_tick) begin
      pre_cnt <= 3'h0;
    end else if (clk_run) begin
      pre_cnt <= pre_cnt + 3'h1;
    end
  end

  // Rate counter advances only on prescaler ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_cnt <= 8'h00;
    end else if (pre_tick) begin
      if (rate_cnt >= rate_last) begin
        rate_cnt <= 8'h00;
      end else begin
        rate_cnt <= rate_cnt + 8'h01;
      end
    end
  end

  // One tick per (pre+1)*2^(rate+1) bus clocks, master only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_rate_tick <= 1'b0;
      if_clk_run <= 1'b1;
    end else begin
      bit_rate_tick <= master && pre_tick && (rate_cnt >= rate_last);
      if_clk_run <= clk_run;
    end
  end

endmodule // spc_pin_rate

/* tb/spc_pin_rate_properties.sv */
/*
  Checker for the pin-control and bit-rate block, bound to its top.
  Assumes one clock, aclk, and a synchronous active-low aresetn.
*/
`timescale 1ns/1ns
module spc_pin_rate_properties
  import spc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic bit_rate_tick,
  input wire logic if_clk_run,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ss_oe,
  input wire logic ss_port_io,
  input wire logic mode_fault_flag,
  input wire logic irq
);
  // ----------------------------------------------------------
  // Bus steps and pin relations
  // ----------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_err_rdata: assert property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  a_tick_single: assert property (bit_rate_tick |=> !bit_rate_tick)
    else $error("bit tick closer than two cycles");
  a_tick_running: assert property (bit_rate_tick |-> if_clk_run)
    else $error("bit tick while clocks stopped");
  a_ss_owner: assert property (ss_oe |-> !ss_port_io)
    else $error("select driven and released at once");
  a_data_oe: assert property (!(mosi_oe && miso_oe))
    else $error("both data drivers on");
  a_irq_cause: assert property (irq |-> $past(mode_fault_flag))
    else $error("interrupt without a fault");
endmodule // spc_pin_rate_properties

bind spc_pin_rate spc_pin_rate_properties u_props (.*);

/* tb/spc_far_dev.sv */
/*
  Far-side serial device: a competing master that can pull select low.
  Assumes the block's pin triples; select carries a pull-up.
*/
`timescale 1ns/1ns
module spc_far_dev (
  input wire logic aclk,
  input wire logic pull_ss_low,
  input wire logic mosi_o,
  input wire logic mosi_oe,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic ss_o,
  input wire logic ss_oe,
  output logic mosi_i,
  output logic miso_i,
  output logic ss_i
);
  logic pat = 1'h0;
  // Undriven data lines toggle so a stale level never looks valid
  always_ff @(posedge aclk) begin
    pat <= ~pat;
  end
  // Wire levels resolved from every party's driver
  assign mosi_i = mosi_oe ? mosi_o : pat;
  assign miso_i = miso_oe ? miso_o : ~pat;
  assign ss_i = ss_oe ? ss_o : !pull_ss_low;
endmodule // spc_far_dev

/* tb/spc_pin_rate_tb.sv */
/*
  Self-checking bench: register access, pin functions, fault interrupt,
  wait gating and bit-rate periods. Assumes the block and far model.
*/
`timescale 1ns/1ns
module spc_pin_rate_tb
  import spc_pkg::*;
;
  logic aclk = 1'h0, aresetn = 1'h0, cpu_in_wait = 1'h0, pull_ss_low = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic shifter_out = 1'h0, shifter_ss_level = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic shifter_in, bit_rate_tick, if_clk_run, ss_port_io;
  logic mode_fault_flag, irq, ss_i, ss_o, ss_oe;
  logic mosi_i, mosi_o, mosi_oe, miso_i, miso_o, miso_oe;
  int failures = 0, checked = 0;

  spc_pin_rate u_dut (.*);
  spc_far_dev u_far (.*);

  // 50 ns bus clock
  always #25 aclk = ~aclk;

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = AXI_OKAY);
    logic aw_ok;
    logic w_ok;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    // Local flags, since a just-scheduled valid still reads its old level
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er = AXI_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask

  // Registered outputs need a few edges after a write lands
  task automatic st;
    repeat (3) @(posedge aclk);
    #1;
  endtask

  // Skip two ticks so the old period has flushed, then time one
  task automatic per(input int pre, input int rate);
    int n;
    wr(OFS_BIT_RATE, 32'(pre * 16 + rate));
    n = 0;
    repeat (2) do @(posedge aclk); while (!bit_rate_tick);
    do begin
      @(posedge aclk);
      n++;
    end while (!bit_rate_tick);
    chk(32'(n), 32'((pre + 1) * (2 << rate)));
  endtask

  task automatic end_sim;
    $display("checked %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------
  // Tests
  // ----------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(OFS_PIN_MODE, 32'h0);
    rd(OFS_BIT_RATE, 32'h0);
    wr(OFS_PIN_MODE, 32'hFF);
    rd(OFS_PIN_MODE, 32'h1B);
    wr(OFS_BIT_RATE, 32'hFF);
    rd(OFS_BIT_RATE, 32'h77);
    wr(8'h14, 32'h1, AXI_SLVERR);
    rd(8'h14, 32'h0, AXI_SLVERR);
    $display("test done: registers");
    shifter_out <= 1'h1;
    // Master, single wire, bidir enable over all eight settings
    for (int i = 0; i < 8; i++) begin
      wr(OFS_MODE_CTRL, {31'h0, i[2]});
      wr(OFS_PIN_MODE, {28'h0, i[1], 2'h0, i[0]});
      st();
      chk(mosi_oe, i[2] & (!i[0] | i[1]));
      chk(miso_oe, !i[2] & (!i[0] | i[1]));
      chk({mosi_o, miso_o}, 2'h3);
      if (i[0] && i[1]) chk(shifter_in, 1'h1);
    end
    $display("test done: data pins");
    wr(OFS_MODE_CTRL, 32'h0);
    wr(OFS_PIN_MODE, 32'h10);
    pull_ss_low <= 1'h1;
    st();
    chk({ss_oe, ss_port_io, mode_fault_flag}, 3'h0);
    // Fault enable off before master, so no fault window opens between
    wr(OFS_PIN_MODE, 32'h0);
    wr(OFS_MODE_CTRL, 32'h1);
    st();
    chk({ss_oe, ss_port_io, mode_fault_flag}, 3'h2);
    wr(OFS_MODE_CTRL, 32'h3);
    wr(OFS_PIN_MODE, 32'h10);
    shifter_ss_level <= 1'h0;
    st();
    chk({ss_o, ss_oe, ss_port_io, mode_fault_flag}, 4'h4);
    @(posedge aclk);
    shifter_ss_level <= 1'h1;
    wr(OFS_MODE_CTRL, 32'h1);
    st();
    chk({ss_oe, ss_port_io, mode_fault_flag, irq}, 4'h2);
    wr(OFS_IRQ_MASK, 32'h1);
    st();
    chk(irq, 1'h1);
    @(posedge aclk);
    pull_ss_low <= 1'h0;
    rd(OFS_IRQ_STATUS, 32'h1);
    st();
    chk({mode_fault_flag, irq}, 2'h0);
    $display("test done: select and fault");
    wr(OFS_PIN_MODE, 32'h2);
    wr(OFS_MODE_CTRL, 32'h5);
    @(posedge aclk);
    cpu_in_wait <= 1'h1;
    st();
    chk(if_clk_run, 1'h0);
    wr(OFS_PIN_MODE, 32'h0);
    st();
    chk(if_clk_run, 1'h1);
    $display("test done: wait gating");
    wr(OFS_MODE_CTRL, 32'h1);
    per(0, 0);
    per(7, 2);
    per(2, 5);
    per(7, 7);
    wr(OFS_MODE_CTRL, 32'h0);
    st();
    repeat (64) begin
      @(posedge aclk);
      if (bit_rate_tick === 1'h1) chk(1'h1, 1'h0);
    end
    $display("test done: bit rate");
    end_sim();
  end

  // Run is under 8000 cycles; the limit leaves ample margin
  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    end_sim();
  end
endmodule // spc_pin_rate_tb
